/* File: logic/dps_fifo.sv */
// Purpose: small flip-flop fifo holding captured write beats
// Assumes: single clock, asynchronous active-low reset
// Notes: in_ready and out_valid are combinational from the count
`timescale 1ns/100ps
`default_nettype none
module dps_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        count <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : dps_fifo
`default_nettype wire

/* File: logic/dps_pkg.sv */
// Purpose: shared constants and types for the burst sram interface block
// Assumes: one core clock, much faster than the sampled pin clocks
// Notes: data width and lane width pick byte (9-bit) or nibble (4-bit) lanes
package dps_pkg;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 3;
    localparam int PIN_CLOCKS = 4;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [2:0] STRAP_DELAY = 3'h4;

    typedef enum logic [1:0] {
        DPS_RD_IDLE = 2'b00,
        DPS_RD_WAIT = 2'b01,
        DPS_RD_BEAT = 2'b10,
        DPS_RD_TAIL = 2'b11
    } dps_rd_state_t;

    typedef enum logic [1:0] {
        DPS_LAST_NONE = 2'b00,
        DPS_LAST_READ = 2'b01,
        DPS_LAST_WRITE = 2'b10
    } dps_last_t;
endpackage : dps_pkg

/* File: logic/dps_sram_core.sv */
// Purpose: burst sram with separate read and write ports, four-word bursts
// Assumes: pin clocks and pins are oversampled by CLK, at least 8x slower
// Notes: pins must hold steady for three CLK cycles around each pin clock edge
`timescale 1ns/100ps
`default_nettype none
// Function
// - write select low, read high starts write
// - read select low starts four-beat read
// - low lane select stores lane, high keeps
// - write beats taken on both input clocks
// - read beats launched on output clock pair, or on K pair in single clock mode
// - after power up, deselected and outputs off
// - burst covers A, A+1, A+2, A+3
// - second consecutive same-port request is ignored
// - both selected: read wins unless read before
module dps_sram_core #(
    parameter int DATA_W = dps_pkg::DATA_W,
    parameter int LANE_W = dps_pkg::LANE_W,
    parameter int LANES = dps_pkg::LANES,
    parameter int ADDR_W = dps_pkg::ADDR_W,
    parameter int FIFO_DEPTH = dps_pkg::FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic K,
    input wire logic K_N,
    input wire logic C,
    input wire logic C_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic READ_PORT_SELECT_N,
    input wire logic WRITE_PORT_SELECT_N,
    input wire logic [LANES-1:0] LANE_WRITE_SELECT_N,
    input wire logic [DATA_W-1:0] D,
    output logic [DATA_W-1:0] Q,
    output logic Q_OE,
    output logic SINGLE_CLOCK_MODE
);
    localparam int SW = dps_pkg::PIN_CLOCKS + 2 + LANES + DATA_W + ADDR_W;
    localparam int FW = ADDR_W + LANES + DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling: three flops, a change counts once stages two and three agree
    logic [SW-1:0] pins;
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [3:0] clk_lvl;
    logic [3:0] clk_rise;
    logic [3:0] ck2;
    logic [3:0] ck3;
    logic rps3;
    logic wps3;
    logic [LANES-1:0] lane3;
    logic [DATA_W-1:0] d3;
    logic [ADDR_W-1:0] a3;

    assign pins = {K, K_N, C, C_N, READ_PORT_SELECT_N, WRITE_PORT_SELECT_N,
                   LANE_WRITE_SELECT_N, D, ADDR};
    assign ck2 = s2[SW-1 -: 4];
    assign ck3 = s3[SW-1 -: 4];
    assign {rps3, wps3, lane3, d3, a3} = s3[SW-5:0];
    assign clk_rise = ~(ck2 ^ ck3) & ck3 & ~clk_lvl;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_lvl <= 4'hf;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ck2[i] == ck3[i]) begin
                    clk_lvl[i] <= ck3[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap: caught a few cycles after release so the samplers have settled
    logic [2:0] strap_cnt;
    logic strap_done;
    logic single_mode;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_cnt <= 3'h0;
            strap_done <= 1'b0;
            single_mode <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 3'h1;
            if (strap_cnt == dps_pkg::STRAP_DELAY) begin
                strap_done <= 1'b1;
                single_mode <= ck3[1] & ck3[0];
            end
        end
    end

    assign SINGLE_CLOCK_MODE = single_mode;

    logic k_rise;
    logic kn_rise;
    logic oc_rise;
    logic ocn_rise;

    // nothing is decoded until the strap is known, so the ports stay deselected
    assign k_rise = clk_rise[3] & strap_done;
    assign kn_rise = clk_rise[2] & strap_done;
    assign oc_rise = single_mode ? k_rise : clk_rise[1] & strap_done;
    assign ocn_rise = single_mode ? kn_rise : clk_rise[0] & strap_done;

    ////////////////////////////////////////////////////////////////////////
    // port arbitration
    dps_pkg::dps_last_t last_start;
    logic req_rd;
    logic req_wr;
    logic rd_go;
    logic wr_go;
    logic fifo_in_ready;

    assign req_rd = k_rise & ~rps3;
    assign req_wr = k_rise & ~wps3;
    assign rd_go = req_rd & (last_start != dps_pkg::DPS_LAST_READ);
    // a full beat buffer refuses new writes rather than dropping beats later
    assign wr_go = req_wr & ~rd_go & fifo_in_ready
                   & (last_start != dps_pkg::DPS_LAST_WRITE);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            last_start <= dps_pkg::DPS_LAST_NONE;
        end else if (k_rise) begin
            if (rd_go) begin
                last_start <= dps_pkg::DPS_LAST_READ;
            end else if (wr_go) begin
                last_start <= dps_pkg::DPS_LAST_WRITE;
            end else begin
                last_start <= dps_pkg::DPS_LAST_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write sequencer: beats on K and K_N of cycles t+1 and t+2
    logic wr_active;
    logic [1:0] wr_idx;
    logic [ADDR_W-1:0] wr_base;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_pend_base;
    logic wr_cap;
    logic [FW-1:0] push_data;

    assign wr_cap = wr_active & (wr_idx[0] ? kn_rise : k_rise);
    assign push_data = {wr_base + ADDR_W'(wr_idx), lane3, d3};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_active <= 1'b0;
            wr_idx <= dps_pkg::BEAT_FIRST;
            wr_base <= '0;
            wr_pend <= 1'b0;
            wr_pend_base <= '0;
        end else begin
            if (wr_cap) begin
                wr_idx <= wr_idx + 2'h1;
                if (wr_idx == dps_pkg::BEAT_LAST) begin
                    wr_active <= wr_pend;
                    wr_base <= wr_pend_base;
                    wr_pend <= 1'b0;
                end
            end
            if (wr_go) begin
                if (wr_active) begin
                    wr_pend <= 1'b1;
                    wr_pend_base <= a3;
                end else begin
                    wr_active <= 1'b1;
                    wr_base <= a3;
                    wr_idx <= dps_pkg::BEAT_FIRST;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // beat buffer and array
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FW-1:0] fifo_out;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [ADDR_W-1:0] drain_addr;
    logic [LANES-1:0] drain_sel_n;
    logic [DATA_W-1:0] drain_data;
    logic rd_fetch;

    dps_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(wr_cap),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    assign {drain_addr, drain_sel_n, drain_data} = fifo_out;
    // read fetches own the array in their cycle; the buffer absorbs the stall
    assign fifo_out_ready = ~rd_fetch;

    always_ff @(posedge CLK) begin
        if (fifo_out_valid && fifo_out_ready) begin
            for (int l = 0; l < LANES; l++) begin
                if (!drain_sel_n[l]) begin
                    mem[drain_addr][l*LANE_W +: LANE_W] <= drain_data[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read sequencer: A on C_N of t+1, then alternating edges to C of t+3
    dps_pkg::dps_rd_state_t rd_state;
    logic [1:0] rd_idx;
    logic [ADDR_W-1:0] rd_base;
    logic rd_pend;
    logic [ADDR_W-1:0] rd_pend_base;

    assign rd_fetch = (rd_state == dps_pkg::DPS_RD_BEAT)
                      & (rd_idx[0] ? oc_rise : ocn_rise);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_state <= dps_pkg::DPS_RD_IDLE;
            rd_idx <= dps_pkg::BEAT_FIRST;
            rd_base <= '0;
            rd_pend <= 1'b0;
            rd_pend_base <= '0;
        end else begin
            unique case (rd_state)
                dps_pkg::DPS_RD_IDLE, dps_pkg::DPS_RD_TAIL: begin
                    if (rd_go) begin
                        rd_state <= dps_pkg::DPS_RD_WAIT;
                        rd_base <= a3;
                        rd_idx <= dps_pkg::BEAT_FIRST;
                    end else if (rd_state == dps_pkg::DPS_RD_TAIL && oc_rise) begin
                        rd_state <= dps_pkg::DPS_RD_IDLE;
                    end
                end
                dps_pkg::DPS_RD_WAIT: begin
                    if (k_rise) begin
                        rd_state <= dps_pkg::DPS_RD_BEAT;
                    end
                end
                dps_pkg::DPS_RD_BEAT: begin
                    if (rd_go) begin
                        rd_pend <= 1'b1;
                        rd_pend_base <= a3;
                    end
                    if (rd_fetch) begin
                        rd_idx <= rd_idx + 2'h1;
                        if (rd_idx == dps_pkg::BEAT_LAST) begin
                            rd_pend <= 1'b0;
                            // with zero skew a start lands on the last beat's edge: keep it
                            if (rd_go) begin
                                rd_state <= dps_pkg::DPS_RD_WAIT;
                                rd_base <= a3;
                            end else begin
                                rd_base <= rd_pend_base;
                                rd_state <= rd_pend ? dps_pkg::DPS_RD_BEAT : dps_pkg::DPS_RD_TAIL;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            Q <= '0;
            Q_OE <= 1'b0;
        end else if (rd_fetch) begin
            Q <= mem[rd_base + ADDR_W'(rd_idx)];
            Q_OE <= 1'b1;
        end else if (oc_rise && (rd_state != dps_pkg::DPS_RD_BEAT)) begin
            Q_OE <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    strap_quiet_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !strap_done |-> !Q_OE && rd_state == dps_pkg::DPS_RD_IDLE && !wr_active)
        else $error("activity before strap capture");
    read_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
        rd_go && rd_state == dps_pkg::DPS_RD_IDLE |=> rd_state == dps_pkg::DPS_RD_WAIT
        && rd_base == $past(a3)) else $error("read not started");
    write_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_go && !wr_active |=> wr_active && wr_idx == 2'h0 && wr_base == $past(a3))
        else $error("write not started");
    // starts seen at the previous K rise, kept apart from the arbiter's own state
    logic prev_rd_go;
    logic prev_wr_go;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_rd_go <= 1'b0;
            prev_wr_go <= 1'b0;
        end else if (k_rise) begin
            prev_rd_go <= rd_go;
            prev_wr_go <= wr_go;
        end
    end
    no_repeat_a: assert property (@(posedge CLK) disable iff (!RST_N)
        k_rise |-> !(prev_rd_go && rd_go) && !(prev_wr_go && wr_go))
        else $error("consecutive start accepted");
    arb_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        req_rd && req_wr && fifo_in_ready && last_start == dps_pkg::DPS_LAST_READ
        |=> last_start == dps_pkg::DPS_LAST_WRITE) else $error("write lost arbitration");
    arb_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        req_rd && last_start != dps_pkg::DPS_LAST_READ
        |=> last_start == dps_pkg::DPS_LAST_READ) else $error("read lost arbitration");
    nop_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
        k_rise && rps3 && wps3 |=> last_start == dps_pkg::DPS_LAST_NONE)
        else $error("start without select");
    beat_drive_a: assert property (@(posedge CLK) disable iff (!RST_N)
        rd_fetch |=> Q_OE && Q == $past(mem[rd_base + ADDR_W'(rd_idx)]))
        else $error("read beat not driven");
    lane_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
        fifo_out_valid && fifo_out_ready && (&drain_sel_n)
        |=> mem[$past(drain_addr)] == $past(mem[drain_addr])) else $error("lane altered");
    burst_four_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_cap && wr_idx == 2'h3 && !wr_pend && !wr_go |=> !wr_active)
        else $error("write burst longer than four");
    beat_edge_a: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_cap |-> fifo_in_ready && (k_rise != kn_rise))
        else $error("write beat on wrong edge");

    read_burst_c: cover property (@(posedge CLK) disable iff (!RST_N)
        rd_fetch && rd_idx == 2'h3);
    write_burst_c: cover property (@(posedge CLK) disable iff (!RST_N)
        wr_cap && wr_idx == 2'h3);
    both_sel_c: cover property (@(posedge CLK) disable iff (!RST_N)
        req_rd && req_wr && last_start == dps_pkg::DPS_LAST_READ);
    back_read_c: cover property (@(posedge CLK) disable iff (!RST_N)
        rd_fetch && rd_idx == 2'h3 && rd_pend);
    edge_read_c: cover property (@(posedge CLK) disable iff (!RST_N)
        rd_fetch && rd_idx == 2'h3 && rd_go);
endmodule : dps_sram_core
`default_nettype wire

/* File: tb/dps_ctl_model.sv */
// Purpose: memory controller model driving burst reads and writes into the sram block
// Assumes: pin clocks run only while a schedule is played, 10 CLK per pin clock cycle
// Notes: the bench fills the per-step schedule, then calls run and reads back qs/oes
`timescale 1ns/100ps
`default_nettype none
module dps_ctl_model (
    input wire logic clk,
    output logic k,
    output logic k_n,
    output logic c,
    output logic c_n,
    output logic [dps_pkg::ADDR_W-1:0] addr,
    output logic rd_n,
    output logic wr_n,
    output logic [dps_pkg::LANES-1:0] lanes_n,
    output logic [dps_pkg::DATA_W-1:0] d,
    input wire logic [dps_pkg::DATA_W-1:0] q,
    input wire logic q_oe
);
    logic rs [0:15];
    logic ws [0:15];
    logic [dps_pkg::ADDR_W-1:0] ad [0:15];
    logic [dps_pkg::DATA_W-1:0] dat [0:31];
    logic [dps_pkg::LANES-1:0] ln [0:31];
    logic [dps_pkg::DATA_W-1:0] qs [0:31];
    logic oes [0:31];
    logic single = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // idle pins; both output clocks high only when single clock mode is wanted
    task automatic park();
        k = 1'b0;
        k_n = 1'b1;
        c = single;
        c_n = 1'b1;
    endtask : park
    // released data alternates so a stale capture never matches by luck
    task automatic clear();
        for (int i = 0; i < 32; i++) begin
            dat[i] = i[0] ? 18'h2aaaa : 18'h15555;
            ln[i] = 2'h3;
            qs[i] = 18'h00000;
            oes[i] = 1'b0;
        end
        for (int i = 0; i < 16; i++) begin
            rs[i] = 1'b1;
            ws[i] = 1'b1;
            ad[i] = i[3:0];
        end
    endtask : clear
    // beats A..A+3 on K and K_N of the two following cycles
    task automatic plan_write(input int s, input logic [3:0] a, input logic [71:0] w,
                              input logic [7:0] l);
        ws[s] = 1'b0;
        ad[s] = a;
        for (int i = 0; i < 4; i++) begin
            dat[2*s+2+i] = w[i*18 +: 18];
            ln[2*s+2+i] = l[2*i +: 2];
        end
    endtask : plan_write
    task automatic plan_read(input int s, input logic [3:0] a);
        rs[s] = 1'b0;
        ad[s] = a;
    endtask : plan_read
    // selects and data settle 3 CLK before each pin clock edge and hold 2 CLK after
    task automatic run(input int n);
        for (int h = 0; h < 2*n; h++) begin
            rd_n = h[0] ? 1'b1 : rs[h/2];
            wr_n = h[0] ? 1'b1 : ws[h/2];
            addr = h[0] ? ~ad[h/2] : ad[h/2];
            d = dat[h];
            lanes_n = ln[h];
            repeat (3) @(negedge clk);
            qs[h] = q;
            oes[h] = q_oe;
            k = ~h[0];
            k_n = h[0];
            c = single ? 1'b1 : ~h[0];
            c_n = single ? 1'b1 : h[0];
            repeat (2) @(negedge clk);
        end
    endtask : run
    initial begin
        park();
        clear();
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        lanes_n = 2'h3;
        d = 18'h00000;
    end
endmodule : dps_ctl_model
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the burst sram block against a controller model
// Assumes: CLK 40 MHz, pin clocks 4 MHz, memory contents unknown until written
// Notes: expected memory kept here; only written addresses are ever compared
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic k, k_n, c, c_n, rd_n, wr_n, q_oe, single_mode;
    logic [3:0] addr;
    logic [1:0] lanes_n;
    logic [17:0] d, q;
    logic [17:0] mem [0:15];
    int n_mismatch = 0;
    int num_checks = 0;
    always #12.5 CLK = ~CLK;
    dps_ctl_model ctl (.clk(CLK), .k(k), .k_n(k_n), .c(c), .c_n(c_n), .addr(addr),
        .rd_n(rd_n), .wr_n(wr_n), .lanes_n(lanes_n), .d(d), .q(q), .q_oe(q_oe));
    dps_sram_core uut (.CLK(CLK), .RST_N(RST_N), .K(k), .K_N(k_n), .C(c), .C_N(c_n),
        .ADDR(addr), .READ_PORT_SELECT_N(rd_n), .WRITE_PORT_SELECT_N(wr_n),
        .LANE_WRITE_SELECT_N(lanes_n), .D(d), .Q(q), .Q_OE(q_oe),
        .SINGLE_CLOCK_MODE(single_mode));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // strap levels must be on the output clocks from release on
    task automatic do_reset();
        @(negedge CLK);
        RST_N = 1'b0;
        ctl.park();
        repeat (20) @(negedge CLK);
        RST_N = 1'b1;
        repeat (10) @(negedge CLK);
    endtask : do_reset
    task automatic mwrite(input logic [3:0] a, input logic [71:0] w, input logic [7:0] l);
        logic [3:0] idx;
        for (int i = 0; i < 4; i++) begin
            idx = a + i[3:0];
            for (int j = 0; j < 2; j++) begin
                if (!l[2*i+j]) mem[idx][j*9 +: 9] = w[i*18+j*9 +: 9];
            end
        end
    endtask : mwrite
    task automatic chk_read(input int h0, input logic [3:0] a);
        logic [3:0] idx;
        for (int i = 0; i < 4; i++) begin
            idx = a + i[3:0];
            chk("read word", mem[idx], ctl.qs[h0+i]);
            chk("read enable", 18'h00001, {17'h00000, ctl.oes[h0+i]});
        end
    endtask : chk_read
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        chk("power-up enable", 18'h00000, {17'h00000, q_oe});
        chk("power-up strap", 18'h00000, {17'h00000, single_mode});
        $display("test power_up done");
    endtask : t_power_up
    // write at 14 wraps to 0; a second write on the next K rise must be dropped
    task automatic t_pipeline();
        logic [71:0] w1 = {18'h3a5c1, 18'h01234, 18'h2fedc, 18'h15a5a};
        logic [71:0] w2 = {18'h0c3c3, 18'h3f00f, 18'h12345, 18'h2b6d9};
        ctl.clear();
        ctl.plan_write(0, 4'he, w1, 8'h00);
        ctl.ws[1] = 1'b0;
        ctl.ad[1] = 4'h4;
        ctl.plan_write(2, 4'h4, w2, 8'h00);
        ctl.plan_read(6, 4'he);
        ctl.plan_read(8, 4'h4);
        ctl.plan_read(9, 4'h0);
        ctl.run(13);
        mwrite(4'he, w1, 8'h00);
        mwrite(4'h4, w2, 8'h00);
        for (int h = 0; h < 16; h++) chk("idle enable", 18'h0, {17'h0, ctl.oes[h]});
        chk_read(16, 4'he);
        chk_read(20, 4'h4);
        chk("dropped read", 18'h00000, {17'h00000, ctl.oes[25]});
        $display("test pipeline done");
    endtask : t_pipeline
    // both selects low three times from idle: read, write, then read after the write
    task automatic t_arbitrate();
        logic [71:0] w3 = {18'h01111, 18'h12222, 18'h23333, 18'h34444};
        ctl.clear();
        ctl.plan_read(0, 4'he);
        ctl.ws[0] = 1'b0;
        ctl.plan_write(1, 4'h8, w3, 8'h00);
        ctl.rs[1] = 1'b0;
        ctl.plan_read(2, 4'h4);
        ctl.ws[2] = 1'b0;
        ctl.plan_read(5, 4'h8);
        ctl.run(10);
        chk_read(4, 4'he);
        chk_read(8, 4'h4);
        mwrite(4'h8, w3, 8'h00);
        chk_read(14, 4'h8);
        $display("test arbitrate done");
    endtask : t_arbitrate
    // lane selects change on every beat: lower, upper, none, both
    task automatic t_lanes();
        logic [71:0] w4 = {18'h1e1e1, 18'h2d2d2, 18'h3c3c3, 18'h04b4b};
        ctl.clear();
        ctl.plan_write(0, 4'h4, w4, 8'b00_11_01_10);
        ctl.plan_read(4, 4'h4);
        ctl.run(8);
        mwrite(4'h4, w4, 8'b00_11_01_10);
        chk_read(12, 4'h4);
        $display("test lanes done");
    endtask : t_lanes
    // output clocks strapped high: read beats follow the input clock pair
    task automatic t_single();
        ctl.single = 1'b1;
        do_reset();
        chk("strap", 18'h00001, {17'h00000, single_mode});
        ctl.clear();
        ctl.plan_read(0, 4'h8);
        ctl.run(6);
        chk_read(4, 4'h8);
        $display("test single_clock done");
    endtask : t_single
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        t_power_up();
        t_pipeline();
        t_arbitrate();
        t_lanes();
        t_single();
        end_sim();
    end
    // whole run is about 430 CLK; a hang past this is a failure
    initial begin
        repeat (3000) @(posedge CLK);
        n_mismatch++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
